// >>> sdf_pkg.sv
package sdf_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets on the register bus.
    localparam logic [7:0] SDF_CTRL_OFS = 8'h00;
    localparam logic [7:0] SDF_STAT_OFS = 8'h04;
    localparam logic [7:0] SDF_DATA_OFS = 8'h08;

    // Field positions of the fifo_control register.
    localparam int SDF_RST_BIT = 0;
    localparam int SDF_DIR_BIT = 1;
    localparam int SDF_LEV_BIT = 2;
    localparam int SDF_ACC_LSB = 3;
    localparam int SDF_ACC_MSB = 4;
    localparam int SDF_CTRL_MSB = 4;

    // Reset value of the fifo_control register.
    localparam logic [4:0] SDF_CTRL_RESET = 5'h00;

    // Field positions of the status register.
    localparam int SDF_STAT_FULL_BIT = 0;
    localparam int SDF_STAT_EMPTY_BIT = 1;
    localparam int SDF_STAT_CNT_LSB = 16;

    // Direction codes of the transfer_direction field.
    localparam logic SDF_DIR_READ = 1'b0;
    localparam logic SDF_DIR_WRITE = 1'b1;

    // Host bytes per access for access-width code zero.
    localparam logic [2:0] SDF_ACC_MAX_BYTES = 3'h4;

    // Card-side bytes between two requests, per threshold setting.
    localparam logic [6:0] SDF_THR_LOW = 7'h20;
    localparam logic [6:0] SDF_THR_HIGH = 7'h40;

    // Register bus response codes.
    localparam logic [1:0] SDF_RESP_OKAY = 2'h0;
    localparam logic [1:0] SDF_RESP_SLVERR = 2'h2;

endpackage

// >>> sdf_fifo_ctrl.sv
`timescale 1ns/10ps
module sdf_fifo_ctrl
    import sdf_pkg::*;
#(
    parameter int DEPTH = 256
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic card_in_valid,
    input wire logic [7:0] card_in_data,
    output logic card_in_ready,
    output logic card_out_valid,
    output logic [7:0] card_out_data,
    input wire logic card_out_ready,
    output logic host_full,
    output logic host_empty,
    output logic dma_request,
    output logic threshold_event
);

    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;
    localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

    // Refuse depths that cannot hold two threshold blocks or do not wrap.
    if (DEPTH < 128 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("DEPTH must be a power of two of at least 128");
    end

    ////////////////////////////////////////////////////////////////////////
    // State.
    logic [SDF_CTRL_MSB:0] ctrl_q;
    logic [7:0] mem [DEPTH];
    logic [AW-1:0] wptr_q;
    logic [AW-1:0] rptr_q;
    logic [CW-1:0] cnt_q;
    logic [6:0] moved_q;
    logic dma_q;
    logic aw_v_q;
    logic [7:0] awaddr_q;
    logic w_v_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // Control fields and the host access width in bytes.
    wire logic frst = ctrl_q[SDF_RST_BIT];
    wire logic dir = ctrl_q[SDF_DIR_BIT];
    wire logic lev = ctrl_q[SDF_LEV_BIT];
    wire logic [1:0] acc = ctrl_q[SDF_ACC_MSB:SDF_ACC_LSB];
    wire logic [2:0] host_n = 3'(SDF_ACC_MAX_BYTES - {1'b0, acc});
    wire logic [CW-1:0] host_n_ext = CW'(host_n);
    wire logic [CW-1:0] space = CW'(DEPTH_C - cnt_q);

    // width-based flags.
    // Full means no room for one host access, empty means no whole access.
    assign host_full = space < host_n_ext;
    assign host_empty = cnt_q < host_n_ext;

    ////////////////////////////////////////////////////////////////////////
    // Register bus decode.
    wire logic [7:0] wr_word = {awaddr_q[7:2], 2'b00};
    wire logic [7:0] rd_word = {s_axi_araddr[7:2], 2'b00};
    wire logic wr_ctrl = wr_word == SDF_CTRL_OFS;
    wire logic wr_stat = wr_word == SDF_STAT_OFS;
    wire logic wr_data = wr_word == SDF_DATA_OFS;
    wire logic rd_ctrl = rd_word == SDF_CTRL_OFS;
    wire logic rd_stat = rd_word == SDF_STAT_OFS;
    wire logic rd_data = rd_word == SDF_DATA_OFS;
    wire logic do_wr = aw_v_q && w_v_q && !bvalid_q;
    wire logic ar_hs = s_axi_arvalid && s_axi_arready;

    assign s_axi_awready = !aw_v_q;
    assign s_axi_wready = !w_v_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // Data movement on both sides of the FIFO.
    // direction gating.
    // Host pushes and card pops on a card write, the reverse on a read.
    wire logic push_host = do_wr && wr_data && dir == SDF_DIR_WRITE &&
        !host_full && !frst;
    wire logic pop_host = ar_hs && rd_data && dir == SDF_DIR_READ &&
        !host_empty && !frst;
    assign card_in_ready = dir == SDF_DIR_READ && cnt_q != DEPTH_C && !frst;
    assign card_out_valid = dir == SDF_DIR_WRITE && cnt_q != '0 && !frst;
    assign card_out_data = mem[rptr_q];
    wire logic push_card = card_in_valid && card_in_ready;
    wire logic pop_card = card_out_valid && card_out_ready;
    wire logic card_xfer = push_card || pop_card;

    // Pointer and count steps of this cycle.
    wire logic [2:0] push_n = push_host ? host_n : {2'b00, push_card};
    wire logic [2:0] pop_n = pop_host ? host_n : {2'b00, pop_card};
    wire logic [CW-1:0] cnt_d = CW'(cnt_q + CW'(push_n) - CW'(pop_n));
    wire logic [AW-1:0] wptr_d = AW'(wptr_q + AW'(push_n));
    wire logic [AW-1:0] rptr_d = AW'(rptr_q + AW'(pop_n));

    // threshold size.
    // The card-side byte count wraps at 32 or 64 bytes.
    wire logic [6:0] thr_m1 = 7'((lev ? SDF_THR_HIGH : SDF_THR_LOW) - 7'h01);
    wire logic thr_hit = card_xfer && moved_q >= thr_m1;

    assign dma_request = dma_q;
    assign threshold_event = dma_q;

    ////////////////////////////////////////////////////////////////////////
    // Byte lanes: write enables, addresses and the read word.
    logic [3:0] lane_we;
    logic [AW-1:0] lane_addr [4];
    logic [7:0] lane_wdata [4];
    logic [7:0] lane_rdata [4];

    for (genvar i = 0; i < 4; i++) begin : g_lane
        assign lane_we[i] = (push_host && 3'(i) < host_n) ||
            (push_card && i == 0);
        assign lane_addr[i] = AW'(wptr_q + AW'(i));
        assign lane_wdata[i] = push_host ? wdata_q[8*i +: 8] : card_in_data;
        // Lanes above the access width read as zero.
        assign lane_rdata[i] = 3'(i) < host_n ? mem[AW'(rptr_q + AW'(i))] :
            8'h00;
    end

    wire logic [31:0] data_word = {lane_rdata[3], lane_rdata[2],
        lane_rdata[1], lane_rdata[0]};
    wire logic [31:0] stat_word = (32'(cnt_q) << SDF_STAT_CNT_LSB) |
        (32'(host_full) << SDF_STAT_FULL_BIT) |
        (32'(host_empty) << SDF_STAT_EMPTY_BIT);
    wire logic [31:0] rd_mux = rd_ctrl ? 32'(ctrl_q) :
        rd_stat ? stat_word :
        rd_data && pop_host ? data_word : 32'h0000_0000;
    wire logic rd_ok = rd_ctrl || rd_stat || (rd_data && pop_host);
    wire logic wr_ok = wr_ctrl || wr_stat || (wr_data && push_host);

    ////////////////////////////////////////////////////////////////////////
    // FIFO storage; data bytes need no reset.
    always_ff @(posedge aclk) begin
        for (int k = 0; k < 4; k++) begin
            if (lane_we[k]) begin
                mem[lane_addr[k]] <= lane_wdata[k];
            end
        end
    end

    // Control register; byte lane zero carries every field.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= SDF_CTRL_RESET;
        end else if (do_wr && wr_ctrl && wstrb_q[0]) begin
            ctrl_q <= wdata_q[SDF_CTRL_MSB:0];
        end
    end

    // state reset.
    // Pointers, count and threshold counter clear while fifo_state_reset is 1.
    always_ff @(posedge aclk) begin
        if (!aresetn || frst) begin
            wptr_q <= '0;
            rptr_q <= '0;
            cnt_q <= '0;
            moved_q <= 7'h00;
            dma_q <= 1'b0;
        end else begin
            wptr_q <= wptr_d;
            rptr_q <= rptr_d;
            cnt_q <= cnt_d;
            moved_q <= thr_hit ? 7'h00 : 7'(moved_q + 7'(card_xfer));
            dma_q <= thr_hit;
        end
    end

    // Write address and write data are held until both have arrived.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_v_q <= 1'b0;
            awaddr_q <= 8'h00;
            w_v_q <= 1'b0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else begin
            if (s_axi_awvalid && !aw_v_q) begin
                aw_v_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end else if (do_wr) begin
                aw_v_q <= 1'b0;
            end
            if (s_axi_wvalid && !w_v_q) begin
                w_v_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end else if (do_wr) begin
                w_v_q <= 1'b0;
            end
        end
    end

    // Write response; refused data pushes and unmapped words give SLVERR.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= SDF_RESP_OKAY;
        end else if (do_wr) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_ok ? SDF_RESP_OKAY : SDF_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // Read answer, one cycle after the address is taken.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rresp_q <= SDF_RESP_OKAY;
            rdata_q <= 32'h0000_0000;
        end else if (ar_hs) begin
            rvalid_q <= 1'b1;
            rresp_q <= rd_ok ? SDF_RESP_OKAY : SDF_RESP_SLVERR;
            rdata_q <= rd_mux;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks on the FIFO control behaviour.
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_host_push;
        push_host && !pop_card;
    endsequence

    sequence s_reset_held;
        frst ##1 frst;
    endsequence

    a_push_adds_width: assert property (
        s_host_push |=> cnt_q == CW'($past(cnt_q) + CW'($past(host_n))))
        else $error("Host push did not add the access width");

    a_full_refuses_push: assert property (
        do_wr && wr_data && host_full |=> s_axi_bvalid &&
        s_axi_bresp == SDF_RESP_SLVERR)
        else $error("Push into a full FIFO was not refused");

    a_request_spacing: assert property (
        dma_request |-> $past(card_xfer) && $past(moved_q) == $past(thr_m1))
        else $error("Request not at the threshold byte count");

    a_card_follows_dir: assert property (
        (card_in_ready |-> dir == SDF_DIR_READ) and
        (card_out_valid |-> dir == SDF_DIR_WRITE))
        else $error("Card side active against the direction");

    a_dir_refuses_read: assert property (
        ar_hs && rd_data && dir == SDF_DIR_WRITE |=>
        s_axi_rvalid && s_axi_rresp == SDF_RESP_SLVERR)
        else $error("Data read in the write direction was accepted");

    a_pop_takes_width: assert property (
        pop_host && !push_card |=>
        cnt_q == CW'($past(cnt_q) - CW'($past(host_n))))
        else $error("Host pop did not remove the access width");

    a_empty_refuses_pop: assert property (
        ar_hs && rd_data && host_empty |=>
        s_axi_rvalid && s_axi_rresp == SDF_RESP_SLVERR)
        else $error("Read from an empty FIFO was not refused");

    a_reset_refuses_pop: assert property (
        ar_hs && rd_data && frst |=>
        s_axi_rvalid && s_axi_rresp == SDF_RESP_SLVERR)
        else $error("Data read while in FIFO reset was accepted");

    a_reset_clears_state: assert property (
        s_reset_held |-> cnt_q == '0 && moved_q == 7'h00 &&
        !card_out_valid && !card_in_ready && !dma_request)
        else $error("FIFO state not held while in reset");

endmodule

// >>> sdf_host_model.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////
// Bus master that stands in for the processor or the DMA engine.
module sdf_host_model (
    input wire logic aclk,
    output logic [7:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    output logic [7:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    // All requests idle at time zero.
    initial begin
        awaddr = 8'h00;
        awvalid = 1'b0;
        wdata = 32'h0;
        wstrb = 4'hF;
        wvalid = 1'b0;
        bready = 1'b0;
        araddr = 8'h00;
        arvalid = 1'b0;
        rready = 1'b0;
    end

    // Write with every byte lane enabled.
    task automatic wr(input logic [7:0] a, input logic [31:0] v,
                      output logic [1:0] resp);
        wr_strb(a, v, 4'hF, resp);
    endtask

    // Write: a released channel shows inverted, not stale, values.
    task automatic wr_strb(input logic [7:0] a, input logic [31:0] v,
                           input logic [3:0] s, output logic [1:0] resp);
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= v;
        wstrb <= s;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awvalid && awready) begin
                awvalid <= 1'b0;
                awaddr <= ~a;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
                wdata <= ~v;
                wstrb <= ~s;
            end
            if (bvalid) break;
        end
        resp = bresp;
        bready <= 1'b0;
    endtask

    // Read: holds the address until taken, then waits for the data.
    task automatic rd(input logic [7:0] a, output logic [31:0] v,
                      output logic [1:0] resp);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arvalid && arready) begin
                arvalid <= 1'b0;
                araddr <= ~a;
            end
            if (rvalid) break;
        end
        v = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask
endmodule

// >>> sdf_fifo_ctrl_tb.sv
`timescale 1ns/10ps
module sdf_fifo_ctrl_tb
    import sdf_pkg::*;
;
    localparam int DEPTH = 128;
    logic aclk, aresetn, card_in_valid, card_out_ready;
    logic card_in_ready, card_out_valid, host_full, host_empty;
    logic dma_request, threshold_event;
    logic [7:0] card_in_data, card_out_data, awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata, d;
    logic [1:0] bresp, rresp, r;
    logic [3:0] wstrb;
    logic [7:0] model_q[$];
    int n_errors = 0, compares = 0, n_dma = 0, nb, moved;
    integer seed = 35;

    ////////////////////////////////////////////////////////////////////////
    // Clock of 100 ns period.
    initial aclk = 1'b0;
    always #50 aclk = ~aclk;

    sdf_fifo_ctrl #(.DEPTH(DEPTH)) u_dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .card_in_valid(card_in_valid),
        .card_in_data(card_in_data), .card_in_ready(card_in_ready),
        .card_out_valid(card_out_valid), .card_out_data(card_out_data),
        .card_out_ready(card_out_ready), .host_full(host_full),
        .host_empty(host_empty), .dma_request(dma_request),
        .threshold_event(threshold_event));

    sdf_host_model u_host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready));

    ////////////////////////////////////////////////////////////////////////
    // Compares one value and records a mismatch.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Counts request pulses; the threshold event must track the request.
    always @(posedge aclk) begin
        if (aresetn === 1'b1 && dma_request === 1'b1) n_dma++;
        if (aresetn === 1'b1 && dma_request !== threshold_event) begin
            chk({31'h0, threshold_event}, {31'h0, dma_request});
        end
    end

    // Takes one host word of nb bytes from the model, lane zero first.
    function automatic logic [31:0] take(input int n);
        logic [31:0] w;
        w = 32'h0;
        for (int i = 0; i < n; i++) w[8*i +: 8] = model_q.pop_front();
        return w;
    endfunction

    // Status word and flag pins against the model's fill level.
    task automatic chk_stat(input int n);
        logic [31:0] e;
        e = {16'(model_q.size()), 14'h0, 1'(model_q.size() < n),
             1'(DEPTH - model_q.size() < n)};
        u_host.rd(SDF_STAT_OFS, d, r);
        chk(d, e);
        chk({30'h0, host_empty, host_full}, {30'h0, e[1:0]});
    endtask

    task automatic cfg(input int c, input logic dir);
        logic [31:0] v;
        v = {27'h0, 2'(c), 1'(c), dir, 1'b0};
        u_host.wr(SDF_CTRL_OFS, v | 32'h1, r);
        chk({31'h0, card_in_ready}, 32'h0);
        u_host.rd(SDF_DATA_OFS, d, r);
        chk({30'h0, r}, {30'h0, SDF_RESP_SLVERR});
        u_host.wr(SDF_CTRL_OFS, v, r);
        u_host.rd(SDF_CTRL_OFS, d, r);
        chk(d, v);
        model_q.delete();
        n_dma = 0;
    endtask

    // Card side delivers n random bytes into the buffer.
    task automatic card_push(input int n);
        repeat (n) begin
            card_in_data <= 8'($random(seed));
            card_in_valid <= 1'b1;
            @(posedge aclk);
            while (!card_in_ready) @(posedge aclk);
            model_q.push_back(card_in_data);
        end
        card_in_valid <= 1'b0;
    endtask

    // Card side drains n bytes while stalling at random.
    task automatic card_pull(input int n);
        int k = 0;
        while (k < n) begin
            card_out_ready <= 1'($random(seed));
            @(posedge aclk);
            if (card_out_valid && card_out_ready) begin
                chk({24'h0, card_out_data}, {24'h0, model_q.pop_front()});
                k++;
            end
        end
        card_out_ready <= 1'b0;
    endtask

    task automatic summarize();
        $display("compares %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence: reset values, then every width in both directions.
    initial begin
        aresetn = 1'b0;
        card_in_valid = 1'b0;
        card_in_data = 8'h00;
        card_out_ready = 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        u_host.rd(SDF_CTRL_OFS, d, r);
        chk(d, {27'h0, SDF_CTRL_RESET});
        chk_stat(4);
        u_host.rd(8'h0C, d, r);
        chk({30'h0, r}, {30'h0, SDF_RESP_SLVERR});
        u_host.wr_strb(SDF_CTRL_OFS, 32'h0000_001E, 4'hE, r);
        u_host.rd(SDF_CTRL_OFS, d, r);
        chk(d, {27'h0, SDF_CTRL_RESET});
        $display("test reset done");
        for (int dir = 0; dir < 2; dir++) begin
            for (int c = 0; c < 4; c++) begin
                nb = 4 - c;
                cfg(c, 1'(dir));
                if (dir == 0) begin
                    card_push(64);
                    moved = 64;
                    while (model_q.size() >= nb) begin
                        u_host.rd(SDF_DATA_OFS, d, r);
                        chk(d, take(nb));
                    end
                end else begin
                    u_host.rd(SDF_DATA_OFS, d, r);
                    chk({30'h0, r}, {30'h0, SDF_RESP_SLVERR});
                    while (model_q.size() + nb <= DEPTH) begin
                        d = $random(seed);
                        u_host.wr(SDF_DATA_OFS, d, r);
                        chk({30'h0, r}, {30'h0, SDF_RESP_OKAY});
                        for (int i = 0; i < nb; i++) model_q.push_back(d[8*i +: 8]);
                    end
                    chk_stat(nb);
                    u_host.wr(SDF_DATA_OFS, 32'hFFFFFFFF, r);
                    chk({30'h0, r}, {30'h0, SDF_RESP_SLVERR});
                    moved = model_q.size();
                    card_pull(moved);
                end
                chk_stat(nb);
                u_host.rd(SDF_DATA_OFS, d, r);
                chk({30'h0, r}, {30'h0, SDF_RESP_SLVERR});
                chk(32'(n_dma), 32'(moved / (c[0] ? 64 : 32)));
                $display("test dir %0d width code %0d done", dir, c);
            end
        end
        // Reset in mid-run with bytes held in the buffer.
        cfg(0, 1'b0);
        card_push(8);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        model_q.delete();
        u_host.rd(SDF_CTRL_OFS, d, r);
        chk(d, {27'h0, SDF_CTRL_RESET});
        chk_stat(4);
        $display("test mid-run reset done");
        summarize();
    end

    // Cuts a hang short well beyond the expected run length.
    initial begin
        repeat (60000) @(posedge aclk);
        n_errors++;
        $display("BAD %0t watchdog expired", $time);
        summarize();
    end
endmodule
